// file: inc/itp_pkg.sv
// Purpose: constants shared by the test pattern loopback block
// Assumes: 32-bit APB register bus, up to 32 links in one group
// Notes: all offsets are byte addresses of aligned words
package itp_pkg;
  // group geometry
  localparam int ITP_LINKS = 32;
  localparam int ITP_LID_W = 5;
  localparam int ITP_PAT_W = 8;
  // register byte offsets
  localparam logic [7:0] ITP_OFF_CTRL = 8'h00;
  localparam logic [7:0] ITP_OFF_STATUS = 8'h04;
  localparam logic [7:0] ITP_OFF_RECOG = 8'h08;
  // control word fields
  localparam int ITP_CTRL_EN_BIT = 0;
  localparam int ITP_CTRL_LID_LSB = 8;
  localparam int ITP_CTRL_PAT_LSB = 16;
  // status word fields
  localparam int ITP_ST_ACT_BIT = 0;
  localparam int ITP_ST_PEND_BIT = 1;
  localparam int ITP_ST_CHG_BIT = 2;
  localparam int ITP_ST_LID_LSB = 8;
  localparam int ITP_ST_PAT_LSB = 16;
  // reset values and codes
  localparam logic [ITP_PAT_W-1:0] ITP_PAT_IDLE = 8'hFF;
  localparam logic [ITP_PAT_W-1:0] ITP_PAT_RST = 8'h00;
  localparam logic [ITP_LID_W-1:0] ITP_LID_RST = 5'h00;
  localparam logic [ITP_LINKS-1:0] ITP_RECOG_RST = 32'h00000000;
  // frame boundaries counted after a load; a changed transmit request is held at least three frames
  localparam logic [1:0] ITP_HOLD_FRAMES = 2'h2;
endpackage

// file: inc/itp_mem_if.sv
// Purpose: carrier between the loopback core and its pattern store
// Assumes: one write and one registered read port
// Notes: read data appear one clock after the address
`timescale 1ns/1ps
interface itp_mem_if;
  import itp_pkg::*;
  logic wr_en;
  logic [ITP_LID_W-1:0] wr_addr;
  logic [ITP_PAT_W-1:0] wr_data;
  logic [ITP_LID_W-1:0] rd_addr;
  logic [ITP_PAT_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// file: logic/itp_pat_mem.sv
// Purpose: per-link store of the last received transmit test pattern
// Assumes: reset already synchronised by the caller
// Notes: read is registered; a write is visible on the following read
`timescale 1ns/1ps
module itp_pat_mem
  import itp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // store port
  itp_mem_if.mem port
);
  logic [ITP_PAT_W-1:0] store [ITP_LINKS];

  ////////////////////////////////////////////////////////////////////////
  // write side, no reset so it maps onto plain storage
  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  // registered read, idle pattern until first cycle after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port.rd_data <= ITP_PAT_IDLE;
    end else begin
      port.rd_data <= store[port.rd_addr];
    end
  end
endmodule

// file: logic/itp_loop.sv
// Purpose: test pattern request and loopback for one link group
// Assumes: frame_start pulses once per frame; icp_rx_* is a one-cycle cell report
// Notes: transmit fields are sampled by the cell builder of every group link
//
// Contract
// - software may optionally start a transmit test request toward the far end
// - while requested, outgoing cells carry an active test command
// - chosen test link identifier goes into the transmitted link id field
// - any changed request values are sent for at least two consecutive frames
// - unchanged values keep being sent while loopback is still wanted
// - watch received cells on recognised links and flag command changes
// - active on all recognised links and test link: loop its pattern back
// - looped pattern holds until stop, new pattern or other test link
// - inactive command or missing test link returns the all-ones pattern
// - only one test pattern and one test link are tracked per group
`timescale 1ns/1ps
module itp_loop
  import itp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame timing
  input wire logic frame_start,
  // received control cell report
  input wire logic icp_rx_valid,
  input wire logic [ITP_LID_W-1:0] icp_rx_link,
  input wire logic icp_rx_cmd,
  input wire logic [ITP_LID_W-1:0] icp_rx_lid,
  input wire logic [ITP_PAT_W-1:0] icp_rx_pattern,
  // transmitted control cell fields
  output logic tx_test_cmd,
  output logic [ITP_LID_W-1:0] tx_lid,
  output logic [ITP_PAT_W-1:0] tx_pattern,
  output logic [ITP_PAT_W-1:0] tx_rx_pattern,
  // loopback status
  output logic rx_test_active,
  output logic rx_cmd_change
);
  logic rst_meta;
  logic rst_n;
  logic ctl_en;
  logic [ITP_LID_W-1:0] ctl_lid;
  logic [ITP_PAT_W-1:0] ctl_pat;
  logic [ITP_LINKS-1:0] recog;
  logic [1:0] hold_cnt;
  logic chg_flag;
  logic [ITP_LINKS-1:0] cmd_vec;
  logic [ITP_LID_W-1:0] cur_lid;
  logic active_q;
  logic grp_active;
  logic req_differs;
  logic load_tx;
  logic acc;
  logic wr_ctrl;
  logic wr_status;
  logic wr_recog;
  logic rx_recog;
  logic rx_cmd_edge;
  logic [31:0] next_prdata;
  logic next_err;
  itp_mem_if mif ();

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb decode; answer one cycle into the access phase
  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && (paddr == ITP_OFF_CTRL);
  assign wr_status = acc && pwrite && (paddr == ITP_OFF_STATUS);
  assign wr_recog = acc && pwrite && (paddr == ITP_OFF_RECOG);

  // read mux and unmapped detection
  always_comb begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    unique case (paddr)
      ITP_OFF_CTRL: begin
        next_prdata[ITP_CTRL_EN_BIT] = ctl_en;
        next_prdata[ITP_CTRL_LID_LSB +: ITP_LID_W] = ctl_lid;
        next_prdata[ITP_CTRL_PAT_LSB +: ITP_PAT_W] = ctl_pat;
      end
      ITP_OFF_STATUS: begin
        next_prdata[ITP_ST_ACT_BIT] = rx_test_active;
        next_prdata[ITP_ST_PEND_BIT] = req_differs || (hold_cnt != 2'h0);
        next_prdata[ITP_ST_CHG_BIT] = chg_flag;
        next_prdata[ITP_ST_LID_LSB +: ITP_LID_W] = cur_lid;
        next_prdata[ITP_ST_PAT_LSB +: ITP_PAT_W] = tx_rx_pattern;
      end
      ITP_OFF_RECOG: begin
        next_prdata = recog;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // bus answer flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software request and recognised link set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_en <= 1'b0;
      ctl_lid <= ITP_LID_RST;
      ctl_pat <= ITP_PAT_RST;
      recog <= ITP_RECOG_RST;
    end else begin
      if (wr_ctrl) begin
        ctl_en <= pwdata[ITP_CTRL_EN_BIT];
        ctl_lid <= pwdata[ITP_CTRL_LID_LSB +: ITP_LID_W];
        ctl_pat <= pwdata[ITP_CTRL_PAT_LSB +: ITP_PAT_W];
      end
      if (wr_recog) begin
        recog <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit fields move only at a frame boundary once the hold has run out
  assign req_differs = (ctl_en != tx_test_cmd) || (ctl_lid != tx_lid) || (ctl_pat != tx_pattern);
  assign load_tx = frame_start && (hold_cnt == 2'h0) && req_differs;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_test_cmd <= 1'b0;
      tx_lid <= ITP_LID_RST;
      tx_pattern <= ITP_PAT_RST;
    end else if (load_tx) begin
      tx_test_cmd <= ctl_en;
      tx_lid <= ctl_lid;
      tx_pattern <= ctl_pat;
    end
  end

  // hold counter; software may rewrite freely, the wire sees each loaded value at least three frames
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= 2'h0;
    end else if (load_tx) begin
      hold_cnt <= ITP_HOLD_FRAMES;
    end else if (frame_start && (hold_cnt != 2'h0)) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-link received command state
  assign rx_recog = recog[icp_rx_link];
  assign rx_cmd_edge = icp_rx_valid && rx_recog && (icp_rx_cmd != cmd_vec[icp_rx_link]);

  generate
    for (genvar i = 0; i < ITP_LINKS; i++) begin : g_link
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cmd_vec[i] <= 1'b0;
        end else if (icp_rx_valid && (icp_rx_link == ITP_LID_W'(i))) begin
          cmd_vec[i] <= icp_rx_cmd;
        end
      end
    end
  endgenerate

  // change pulse and sticky flag; a new change beats a software clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_cmd_change <= 1'b0;
      chg_flag <= 1'b0;
    end else begin
      rx_cmd_change <= rx_cmd_edge;
      if (rx_cmd_edge) begin
        chg_flag <= 1'b1;
      end else if (wr_status && pwdata[ITP_ST_CHG_BIT]) begin
        chg_flag <= 1'b0;
      end
    end
  end

  // single test link per group, taken from active cells of recognised links
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_lid <= ITP_LID_RST;
    end else if (icp_rx_valid && rx_recog && icp_rx_cmd) begin
      cur_lid <= icp_rx_lid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern store, one entry per link
  assign mif.wr_en = icp_rx_valid;
  assign mif.wr_addr = icp_rx_link;
  assign mif.wr_data = icp_rx_pattern;
  assign mif.rd_addr = cur_lid;

  itp_pat_mem u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .port(mif.mem)
  );

  // active only when every recognised link and the test link itself agree
  assign grp_active = (recog != ITP_RECOG_RST) && ((cmd_vec & recog) == recog) && recog[cur_lid];

  // active flag aligned with the registered read of the store
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      rx_test_active <= 1'b0;
    end else begin
      active_q <= grp_active;
      rx_test_active <= active_q;
    end
  end

  // looped pattern; holds while the test link entry stays the same
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_rx_pattern <= ITP_PAT_IDLE;
    end else if (active_q) begin
      tx_rx_pattern <= mif.rd_data;
    end else begin
      tx_rx_pattern <= ITP_PAT_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write;
    wr_ctrl;
  endsequence

  sequence s_tx_load;
    frame_start && (hold_cnt == 2'h0) && req_differs;
  endsequence

  AST_CTRL_WRITE: assert property (s_ctrl_write |=> ctl_en == $past(pwdata[ITP_CTRL_EN_BIT]))
    else $error("control enable not stored");
  AST_TX_CMD: assert property (s_tx_load |=> tx_test_cmd == $past(ctl_en))
    else $error("test command not taken at frame boundary");
  AST_TX_LID: assert property (s_tx_load |=> tx_lid == $past(ctl_lid) && tx_pattern == $past(ctl_pat))
    else $error("test link id or pattern not transmitted");
  AST_HOLD_TWO: assert property (!$stable({tx_test_cmd, tx_lid, tx_pattern}) |-> hold_cnt == 2'h2)
    else $error("changed request not held two frames");
  AST_STEADY: assert property (!$past(frame_start) |-> $stable({tx_test_cmd, tx_lid, tx_pattern}))
    else $error("request fields moved between frames");
  AST_CHANGE_SEEN: assert property (rx_cmd_edge |=> rx_cmd_change && chg_flag)
    else $error("received command change missed");
  AST_LOOP_COPY: assert property (active_q |=> tx_rx_pattern == $past(mif.rd_data))
    else $error("looped pattern not copied");
  AST_LOOP_HOLD: assert property (active_q && $past(active_q) && $stable(mif.rd_data) |=> $stable(tx_rx_pattern))
    else $error("looped pattern not steady");
  AST_IDLE_ONES: assert property (!grp_active ##1 !active_q |=> tx_rx_pattern == ITP_PAT_IDLE)
    else $error("idle pattern not all ones");
  AST_ONE_LINK: assert property (!$stable(cur_lid) |-> $past(icp_rx_valid && rx_recog && icp_rx_cmd))
    else $error("test link moved without an active cell");
  AST_NO_REQ: assert property (s_tx_load ##0 !ctl_en |=> !tx_test_cmd)
    else $error("inactive command not sent");
endmodule

// file: dv/itp_far_end.sv
// Purpose: far-end unit model giving frame timing and received cell reports
// Assumes: bench calls send_cell; one cell per call
// Notes: unqualified fields show the inverse of the last cell, never a stale copy
`timescale 1ns/1ps
module itp_far_end
  import itp_pkg::*;
#(parameter int FRAME = 32)
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // frame timing
  output logic frame_start,
  // received cell report
  output logic icp_rx_valid,
  output logic [ITP_LID_W-1:0] icp_rx_link,
  output logic icp_rx_cmd,
  output logic [ITP_LID_W-1:0] icp_rx_lid,
  output logic [ITP_PAT_W-1:0] icp_rx_pattern
);
  int fcnt;
  ////////////////////////////////////////////////////////////////
  // frame pulse; first one lands well after the reset window
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fcnt <= 0;
      frame_start <= 1'b0;
    end else begin
      fcnt <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
      frame_start <= (fcnt == FRAME - 1);
    end
  end
  // quiet cell port at time zero
  initial begin
    icp_rx_valid = 1'b0;
    icp_rx_link = 5'h00;
    icp_rx_cmd = 1'b0;
    icp_rx_lid = 5'h00;
    icp_rx_pattern = 8'h00;
  end
  // one cell after gap+1 idle cycles, a slow far end uses a long gap
  task automatic send_cell(input logic [ITP_LID_W-1:0] link, input logic cmd, input logic [ITP_LID_W-1:0] lid,
                           input logic [ITP_PAT_W-1:0] pat, input int gap);
    repeat (gap + 1) @(posedge clock);
    icp_rx_valid <= 1'b1;
    icp_rx_link <= link;
    icp_rx_cmd <= cmd;
    icp_rx_lid <= lid;
    icp_rx_pattern <= pat;
    @(posedge clock);
    icp_rx_valid <= 1'b0;
    icp_rx_link <= ~link;
    icp_rx_cmd <= ~cmd;
    icp_rx_lid <= ~lid;
    icp_rx_pattern <= ~pat;
  endtask
endmodule

// file: dv/itp_loop_bench.sv
// Purpose: self-checking bench for the test pattern loopback block
// Assumes: far-end model supplies frames and cells; APB from bench tasks
// Notes: short frame period keeps the hold windows quick
`timescale 1ns/1ps
module itp_loop_bench;
  import itp_pkg::*;
  localparam int FRAME = 32;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, frame_start, icp_rx_valid, icp_rx_cmd;
  logic tx_test_cmd, rx_test_active, rx_cmd_change;
  logic [ITP_LID_W-1:0] icp_rx_link, icp_rx_lid, tx_lid;
  logic [ITP_PAT_W-1:0] icp_rx_pattern, tx_pattern, tx_rx_pattern;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int chg_cnt = 0;
  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clock = ~clock;
  itp_loop dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .icp_rx_valid(icp_rx_valid), .icp_rx_link(icp_rx_link),
    .icp_rx_cmd(icp_rx_cmd), .icp_rx_lid(icp_rx_lid), .icp_rx_pattern(icp_rx_pattern),
    .tx_test_cmd(tx_test_cmd), .tx_lid(tx_lid), .tx_pattern(tx_pattern), .tx_rx_pattern(tx_rx_pattern),
    .rx_test_active(rx_test_active), .rx_cmd_change(rx_cmd_change));
  itp_far_end #(.FRAME(FRAME)) far (.clock(clock), .resetn(resetn), .frame_start(frame_start),
    .icp_rx_valid(icp_rx_valid), .icp_rx_link(icp_rx_link), .icp_rx_cmd(icp_rx_cmd),
    .icp_rx_lid(icp_rx_lid), .icp_rx_pattern(icp_rx_pattern));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one APB transfer; waits on pready, the cycle ceiling cuts a hang
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl(input logic en, input logic [4:0] lid, input logic [7:0] pat);
    return (32'(en) << ITP_CTRL_EN_BIT) | (32'(lid) << ITP_CTRL_LID_LSB) | (32'(pat) << ITP_CTRL_PAT_LSB);
  endfunction
  task automatic wait_frame();
    do @(posedge clock); while (frame_start !== 1'b1);
    @(posedge clock);
  endtask
  task automatic chk_tx(input logic en, input logic [4:0] lid, input logic [7:0] pat);
    check(32'(tx_test_cmd), 32'(en));
    check(32'(tx_lid), 32'(lid));
    check(32'(tx_pattern), 32'(pat));
  endtask
  task automatic chk_loop(input logic [7:0] pat, input logic act);
    repeat (4) @(posedge clock);
    check(32'(tx_rx_pattern), 32'(pat));
    check(32'(rx_test_active), 32'(act));
  endtask
  ////////////////////////////////////////////////////////////////
  // change pulses and the hang ceiling
  always @(posedge clock) begin
    cycles++;
    if (rx_cmd_change === 1'b1) chg_cnt++;
    if (cycles == 5000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    chk_tx(1'b0, 5'h00, 8'h00);
    check(32'(tx_rx_pattern), 32'(ITP_PAT_IDLE));
    apb(1'b0, 8'h0C, 32'h00000000);
    check(32'(err), 32'h00000001);
    apb(1'b0, ITP_OFF_CTRL, 32'h00000000);
    check(rd, 32'h00000000);
    apb(1'b1, ITP_OFF_CTRL, ctrl(1'b1, 5'h03, 8'hA5));
    wait_frame();
    chk_tx(1'b1, 5'h03, 8'hA5);
    // a change during the hold must wait two more frames
    apb(1'b1, ITP_OFF_CTRL, ctrl(1'b1, 5'h1F, 8'h3C));
    wait_frame();
    chk_tx(1'b1, 5'h03, 8'hA5);
    wait_frame();
    chk_tx(1'b1, 5'h03, 8'hA5);
    wait_frame();
    chk_tx(1'b1, 5'h1F, 8'h3C);
    for (int i = 0; i < 3; i++) begin
      wait_frame();
      chk_tx(1'b1, 5'h1F, 8'h3C);
    end
    apb(1'b1, ITP_OFF_CTRL, 32'h00000000);
    wait_frame();
    chk_tx(1'b0, 5'h00, 8'h00);
    // let the hold run out so the pending status bit is known to be clear
    wait_frame();
    wait_frame();
    // links 0 and 1 recognised, test on link 1
    apb(1'b1, ITP_OFF_RECOG, 32'h00000003);
    apb(1'b0, ITP_OFF_RECOG, 32'h00000000);
    check(rd, 32'h00000003);
    far.send_cell(5'h00, 1'b1, 5'h01, 8'h3C, 0);
    chk_loop(8'hFF, 1'b0);
    far.send_cell(5'h01, 1'b1, 5'h01, 8'h3C, 5);
    chk_loop(8'h3C, 1'b1);
    far.send_cell(5'h00, 1'b1, 5'h01, 8'h77, 0);
    chk_loop(8'h3C, 1'b1);
    far.send_cell(5'h01, 1'b1, 5'h01, 8'h66, 0);
    chk_loop(8'h66, 1'b1);
    // status: active, change seen, test link 1, looped pattern 66
    apb(1'b0, ITP_OFF_STATUS, 32'h00000000);
    check(rd, 32'h00660105);
    apb(1'b1, ITP_OFF_STATUS, 32'h00000004);
    apb(1'b0, ITP_OFF_STATUS, 32'h00000000);
    check(rd, 32'h00660101);
    far.send_cell(5'h05, 1'b1, 5'h05, 8'h11, 0);
    chk_loop(8'h66, 1'b1);
    check(32'(chg_cnt), 32'h00000002);
    far.send_cell(5'h01, 1'b0, 5'h01, 8'h66, 0);
    chk_loop(8'hFF, 1'b0);
    check(32'(chg_cnt), 32'h00000003);
    apb(1'b0, ITP_OFF_STATUS, 32'h00000000);
    check(rd, 32'h00FF0104);
    end_sim();
  end
endmodule
